// ==== include/stbp_regs.vh ====
`ifndef STBP_REGS_VH
`define STBP_REGS_VH
// ============================================================
// Clock and protocol tick
`define STBP_CLK_HZ        125000000
`define STBP_TICK_S        1
`define STBP_TICK_CYCLES   (`STBP_TICK_S * `STBP_CLK_HZ)
`define STBP_HOLD_TICKS    1
// ============================================================
// Register byte offsets
`define STBP_CTRL          12'h000
`define STBP_BID_HI        12'h004
`define STBP_BID_LO        12'h008
`define STBP_BTIMES        12'h00C
`define STBP_AGEING        12'h010
`define STBP_STATUS        12'h014
`define STBP_ROOT_COST     12'h018
`define STBP_DROOT_HI      12'h01C
`define STBP_DROOT_LO      12'h020
`define STBP_ACT_TIMES     12'h024
`define STBP_PORT_BASE     12'h040
`define STBP_PORT_STRIDE   3
// ============================================================
// Control bits (write one to pulse)
`define STBP_CTRL_ROOT     0
`define STBP_CTRL_TC       1
// Time field positions in the times registers
`define STBP_T_MAXAGE      7:0
`define STBP_T_HELLO       15:8
`define STBP_T_FWD         23:16
// Status bits
`define STBP_ST_ISROOT     0
`define STBP_ST_TC         1
`define STBP_ST_TCDET      2
`define STBP_ST_RPORT      31:16
// ============================================================
// Reset values
`define STBP_RST_BID_HI    32'h80000000
`define STBP_RST_BID_LO    32'h00000001
`define STBP_RST_MAXAGE    8'h14
`define STBP_RST_HELLO     8'h02
`define STBP_RST_FWD       8'h0F
`define STBP_RST_AGEING    16'h012C
`define STBP_RST_PCOST     32'h00000013
`endif

// ==== verilog/stbp_bridge.v ====
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "stbp_regs.vh"

// Contract
// - Root bridge holds root path cost of zero.
// - Non-root cost is root port designated cost plus its path cost.
// - Root port is the port with smallest designated cost plus path cost.
// - Ties broken by designated bridge, then designated port, then own port id.
// - While root, root port reads zero and is meaningless.
// - Sent messages carry designated root and own bridge identifier.
// - On expiry of root info or management request, become root candidate.
// - Bridge id priority part is more significant than address part.
// - As root or candidate, use own max age, hello and forward delay.
// - Non-root bridges adopt max age and forward delay from the root.
// - Port listens one forward delay, learns one forward delay, then forwards.
// - Discard received info whose message age exceeds max age.
// - Non-root resends change notices every hello time until acknowledged.
// - Detected change on a root bridge sets topology change indication.
// - Non-root copies change flag; root asserts it during change time.
// - Topology change time is bridge max age plus bridge forward delay.
// - Root sets change flag in every message during the change period.
// - Ageing uses forward delay during topology change, else long ageing.
// - Notice received on designated port sets ack flag in next message.
// - Change notices carry no fields beyond their type.
// - At most one configuration message per port per hold time.
// - Message due during hold is kept pending and sent on hold expiry.
module stbp_bridge #(
  parameter NPORTS      = 4,
  parameter TICK_CYCLES = `STBP_TICK_CYCLES,
  parameter HOLD_TICKS  = `STBP_HOLD_TICKS
) (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [11:0]          paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output wire                 pready,
  output reg                  pslverr,
  input  wire [NPORTS-1:0]    port_en,
  input  wire [NPORTS-1:0]    port_designated,
  input  wire [32*NPORTS-1:0] port_dcost,
  input  wire [64*NPORTS-1:0] port_dbridge,
  input  wire [16*NPORTS-1:0] port_dport,
  input  wire                 info_expired,
  input  wire                 tc_event,
  input  wire                 rx_valid,
  input  wire [NPORTS-1:0]    rx_port_sel,
  input  wire [63:0]          rx_root_id,
  input  wire [7:0]           rx_msg_age,
  input  wire [7:0]           rx_max_age,
  input  wire [7:0]           rx_hello,
  input  wire [7:0]           rx_fwd,
  input  wire                 rx_tc,
  input  wire                 rx_tca,
  input  wire [NPORTS-1:0]    tcn_rx,
  input  wire [NPORTS-1:0]    cfg_due,
  input  wire [NPORTS-1:0]    port_start,
  input  wire [NPORTS-1:0]    port_block,
  output reg                  tick,
  output reg  [NPORTS-1:0]    cfg_tx,
  output reg                  tcn_tx,
  output reg  [63:0]          tx_root_id,
  output reg  [31:0]          tx_cost,
  output reg  [63:0]          tx_bridge_id,
  output reg  [7:0]           tx_max_age,
  output reg  [7:0]           tx_hello,
  output reg  [7:0]           tx_fwd,
  output reg                  tx_tc,
  output reg  [NPORTS-1:0]    tx_tca,
  output reg  [15:0]          root_port,
  output reg  [31:0]          root_cost,
  output wire                 is_root,
  output wire [NPORTS-1:0]    port_learn,
  output wire [NPORTS-1:0]    port_fwd,
  output reg  [15:0]          ageing_time
);

  // Port sequencer states
  localparam [3:0] ST_BLOCK  = 4'b0001;
  localparam [3:0] ST_LISTEN = 4'b0010;
  localparam [3:0] ST_LEARN  = 4'b0100;
  localparam [3:0] ST_FWD    = 4'b1000;

  // ============================================================
  // Configuration and held state
  reg  [31:0]          bid_hi;
  reg  [31:0]          bid_lo;
  reg  [7:0]           br_max_age;
  reg  [7:0]           br_hello;
  reg  [7:0]           br_fwd;
  reg  [15:0]          long_ageing;
  reg  [32*NPORTS-1:0] path_cost;
  reg  [16*NPORTS-1:0] port_id;
  reg  [63:0]          droot;
  reg  [7:0]           rx_max_age_held;
  reg  [7:0]           rx_hello_held;
  reg  [7:0]           rx_fwd_held;
  reg                  rx_tc_held;
  reg                  tc_detected;
  reg                  tc;
  reg  [8:0]           tc_timer;
  reg  [7:0]           tcn_timer;
  reg  [31:0]          tick_cnt;
  reg  [NPORTS-1:0]    root_sel;

  // Priority part on top makes it the most significant in any compare
  wire [63:0] bid = {bid_hi, bid_lo};
  assign is_root = (droot == bid);

  // Active times: own values as root, adopted values otherwise
  wire [7:0] act_max_age = is_root ? br_max_age : rx_max_age_held;
  wire [7:0] act_hello   = is_root ? br_hello   : rx_hello_held;
  wire [7:0] act_fwd     = is_root ? br_fwd     : rx_fwd_held;
  wire [8:0] tc_time     = {1'b0, br_max_age} + {1'b0, br_fwd};

  // Write and read strobes; the slave never inserts wait states
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;

  // ============================================================
  // Functions
  // Ordering key: lower value wins at every stage of the tie-break
  function [127:0] stbp_key;
    input [31:0] cost;
    input [63:0] dbr;
    input [15:0] dprt;
    input [15:0] pid;
    begin
      stbp_key = {cost, dbr, dprt, pid};
    end
  endfunction

  // Port register decode, shared by reads and writes
  function stbp_port_hit;
    input [11:0] addr;
    input integer idx;
    input integer word;
    begin
      stbp_port_hit = (addr == (`STBP_PORT_BASE + idx * 8 + word * 4));
    end
  endfunction

  // ============================================================
  // Protocol tick divider; all timers count these
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b0;
    end
    else if (tick_cnt == TICK_CYCLES - 1)
    begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick     <= 1'b0;
    end
  end

  // ============================================================
  // Root port selection over enabled ports
  reg  [127:0]      best_key;
  reg  [NPORTS-1:0] next_root_sel;
  reg  [31:0]       best_cost;
  reg  [15:0]       best_pid;
  reg  [127:0]      cand;
  integer           i;

  always @*
  begin
    best_key      = {128{1'b1}};
    next_root_sel = {NPORTS{1'b0}};
    best_cost     = 32'h00000000;
    best_pid      = 16'h0000;
    cand          = 128'h0;
    for (i = 0; i < NPORTS; i = i + 1)
    begin
      cand = stbp_key(port_dcost[32*i +: 32] + path_cost[32*i +: 32],
                      port_dbridge[64*i +: 64], port_dport[16*i +: 16],
                      port_id[16*i +: 16]);
      if (port_en[i] && !port_designated[i] && cand < best_key)
      begin
        best_key      = cand;
        next_root_sel = {NPORTS{1'b0}};
        next_root_sel[i] = 1'b1;
        best_cost     = cand[127:96];
        best_pid      = cand[15:0];
      end
    end
  end

  // Registered root port and cost
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      root_port <= 16'h0000;
      root_cost <= 32'h00000000;
      root_sel  <= {NPORTS{1'b0}};
    end
    else if (is_root)
    begin
      root_port <= 16'h0000;
      root_cost <= 32'h00000000;
      root_sel  <= {NPORTS{1'b0}};
    end
    else
    begin
      root_port <= best_pid;
      root_cost <= best_cost;
      root_sel  <= next_root_sel;
    end
  end

  // ============================================================
  // Received configuration info; stale info is dropped outright
  wire rx_fresh = rx_valid && (rx_msg_age <= act_max_age);
  wire rx_take  = rx_fresh && ((rx_port_sel & root_sel) != {NPORTS{1'b0}} || rx_root_id < droot);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      droot           <= {`STBP_RST_BID_HI, `STBP_RST_BID_LO};
      rx_max_age_held <= `STBP_RST_MAXAGE;
      rx_hello_held   <= `STBP_RST_HELLO;
      rx_fwd_held     <= `STBP_RST_FWD;
      rx_tc_held      <= 1'b0;
    end
    else if (info_expired || (wr_en && paddr == `STBP_CTRL && pwdata[`STBP_CTRL_ROOT]))
      droot <= bid;
    else if (rx_take)
    begin
      droot           <= rx_root_id;
      rx_max_age_held <= rx_max_age;
      rx_hello_held   <= rx_hello;
      rx_fwd_held     <= rx_fwd;
      rx_tc_held      <= rx_tc;
    end
  end

  // ============================================================
  // Topology change: detection, notices toward root, root period
  wire tc_set = tc_event || (wr_en && paddr == `STBP_CTRL && pwdata[`STBP_CTRL_TC]);
  wire tc_ack = rx_take && rx_tca && !is_root;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tc_detected <= 1'b0;
      tc_timer    <= 9'h000;
      tcn_timer   <= 8'h00;
      tcn_tx      <= 1'b0;
    end
    else
    begin
      tcn_tx <= 1'b0;
      // New detection wins over an acknowledgement in the same cycle
      if (tc_set)
        tc_detected <= 1'b1;
      else if (tc_ack || is_root)
        tc_detected <= 1'b0;
      if (is_root && (tc_detected || tc_set))
        tc_timer <= tc_time;
      else if (tick && tc_timer != 9'h000)
        tc_timer <= tc_timer - 9'h001;
      // Notices carry type only, so one strobe is enough
      if (tc_detected && !is_root && !tc_ack)
      begin
        if (tcn_timer == 8'h00)
        begin
          tcn_tx    <= 1'b1;
          tcn_timer <= br_hello;
        end
        else if (tick)
          tcn_timer <= tcn_timer - 8'h01;
      end
      else
        tcn_timer <= 8'h00;
    end
  end

  // Indication and filtering ageing choice
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tc          <= 1'b0;
      ageing_time <= `STBP_RST_AGEING;
    end
    else
    begin
      tc          <= is_root ? (tc_timer != 9'h000 || tc_detected) : rx_tc_held;
      ageing_time <= tc ? {8'h00, act_fwd} : long_ageing;
    end
  end

  // ============================================================
  // Per-port transmit pacing, ack flag and forwarding sequencer
  wire [NPORTS-1:0] send_now;
  genvar g;
  generate
    for (g = 0; g < NPORTS; g = g + 1)
    begin : gen_port
      reg [7:0] hold_cnt;
      reg       pending;
      reg [3:0] state;
      reg [7:0] fwd_cnt;
      wire      hold_busy = (hold_cnt != 8'h00);

      // Send immediately when idle, else defer until hold ends
      assign send_now[g] = port_en[g] && !hold_busy && (cfg_due[g] || pending);
      assign port_learn[g] = (state == ST_LEARN) || (state == ST_FWD);
      assign port_fwd[g]   = (state == ST_FWD);

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          hold_cnt  <= 8'h00;
          pending   <= 1'b0;
          tx_tca[g] <= 1'b0;
          cfg_tx[g] <= 1'b0;
        end
        else
        begin
          cfg_tx[g] <= send_now[g];
          if (send_now[g])
            hold_cnt <= HOLD_TICKS[7:0];
          else if (tick && hold_busy)
            hold_cnt <= hold_cnt - 8'h01;
          if (cfg_due[g] && hold_busy)
            pending <= 1'b1;
          else if (send_now[g])
            pending <= 1'b0;
          // Fresh notice wins over the clear by a send
          if (tcn_rx[g] && port_designated[g])
            tx_tca[g] <= 1'b1;
          else if (cfg_tx[g])
            tx_tca[g] <= 1'b0;
        end
      end

      // Listen and learn each last one forward delay
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          state   <= ST_BLOCK;
          fwd_cnt <= 8'h00;
        end
        else if (port_block[g] || !port_en[g])
          state <= ST_BLOCK;
        else
        begin
          case (state)
            ST_BLOCK:
            begin
              if (port_start[g])
              begin
                state   <= ST_LISTEN;
                fwd_cnt <= act_fwd;
              end
            end
            ST_LISTEN, ST_LEARN:
            begin
              if (fwd_cnt == 8'h00)
              begin
                state   <= (state == ST_LISTEN) ? ST_LEARN : ST_FWD;
                fwd_cnt <= act_fwd;
              end
              else if (tick)
                fwd_cnt <= fwd_cnt - 8'h01;
            end
            ST_FWD:
              state <= ST_FWD;
            default:
              state <= ST_BLOCK;
          endcase
        end
      end
    end
  endgenerate

  // Shared message fields, captured whenever any port sends
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_root_id   <= 64'h0;
      tx_bridge_id <= 64'h0;
      tx_cost      <= 32'h00000000;
      tx_max_age   <= 8'h00;
      tx_hello     <= 8'h00;
      tx_fwd       <= 8'h00;
      tx_tc        <= 1'b0;
    end
    else if (send_now != {NPORTS{1'b0}})
    begin
      tx_root_id   <= droot;
      tx_bridge_id <= bid;
      tx_cost      <= root_cost;
      tx_max_age   <= act_max_age;
      tx_hello     <= act_hello;
      tx_fwd       <= act_fwd;
      tx_tc        <= tc;
    end
  end

  // ============================================================
  // APB register writes
  integer k;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bid_hi      <= `STBP_RST_BID_HI;
      bid_lo      <= `STBP_RST_BID_LO;
      br_max_age  <= `STBP_RST_MAXAGE;
      br_hello    <= `STBP_RST_HELLO;
      br_fwd      <= `STBP_RST_FWD;
      long_ageing <= `STBP_RST_AGEING;
      path_cost   <= {NPORTS{`STBP_RST_PCOST}};
      port_id     <= {16*NPORTS{1'b0}};
    end
    else if (wr_en)
    begin
      case (paddr)
        `STBP_BID_HI:
          bid_hi <= pwdata;
        `STBP_BID_LO:
          bid_lo <= pwdata;
        `STBP_BTIMES:
        begin
          br_max_age <= pwdata[`STBP_T_MAXAGE];
          br_hello   <= pwdata[`STBP_T_HELLO];
          br_fwd     <= pwdata[`STBP_T_FWD];
        end
        `STBP_AGEING:
          long_ageing <= pwdata[15:0];
        default:
        begin
          for (k = 0; k < NPORTS; k = k + 1)
          begin
            if (stbp_port_hit(paddr, k, 0))
              path_cost[32*k +: 32] <= pwdata;
            if (stbp_port_hit(paddr, k, 1))
              port_id[16*k +: 16] <= pwdata[15:0];
          end
        end
      endcase
    end
  end

  // Read data captured in setup so the access phase is zero-wait
  reg [31:0] next_prdata;
  reg        next_err;
  integer    m;
  always @*
  begin
    next_prdata = 32'h00000000;
    next_err    = 1'b0;
    case (paddr)
      `STBP_CTRL:      next_prdata = 32'h00000000;
      `STBP_BID_HI:    next_prdata = bid_hi;
      `STBP_BID_LO:    next_prdata = bid_lo;
      `STBP_BTIMES:    next_prdata = {8'h00, br_fwd, br_hello, br_max_age};
      `STBP_AGEING:    next_prdata = {16'h0000, long_ageing};
      `STBP_STATUS:    next_prdata = {root_port, 13'h0000, tc_detected, tc, is_root};
      `STBP_ROOT_COST: next_prdata = root_cost;
      `STBP_DROOT_HI:  next_prdata = droot[63:32];
      `STBP_DROOT_LO:  next_prdata = droot[31:0];
      `STBP_ACT_TIMES: next_prdata = {ageing_time[7:0], act_fwd, act_hello, act_max_age};
      default:
      begin
        next_err = 1'b1;
        for (m = 0; m < NPORTS; m = m + 1)
        begin
          if (stbp_port_hit(paddr, m, 0))
          begin
            next_prdata = path_cost[32*m +: 32];
            next_err    = 1'b0;
          end
          if (stbp_port_hit(paddr, m, 1))
          begin
            next_prdata = {16'h0000, port_id[16*m +: 16]};
            next_err    = 1'b0;
          end
        end
      end
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= rd_en ? next_prdata : 32'h00000000;
      pslverr <= next_err;
    end
  end

endmodule

// ==== sim/stbp_bridge_properties.sv ====
`timescale 1ns/1ps
// ==========================================
// Port-level checker for the bridge block
module stbp_checker #(
  parameter NPORTS      = 4,
  parameter TICK_CYCLES = 125000000
) (
  input wire              pclk,
  input wire              presetn,
  input wire [NPORTS-1:0] tcn_rx,
  input wire              tick,
  input wire [NPORTS-1:0] cfg_tx,
  input wire              tcn_tx,
  input wire [63:0]       tx_root_id,
  input wire [63:0]       tx_bridge_id,
  input wire [NPORTS-1:0] tx_tca,
  input wire [15:0]       root_port,
  input wire [31:0]       root_cost,
  input wire              is_root,
  input wire [NPORTS-1:0] port_learn,
  input wire [NPORTS-1:0] port_fwd
);
  reg [31:0] gap;
  reg        seen;
  // Cycles since last tick; the first tick after reset has no reference
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap  <= 32'h0;
      seen <= 1'b0;
    end
    else
    begin
      gap  <= tick ? 32'h0 : gap + 32'h1;
      seen <= seen | tick;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Assertions
  root_cost_a: assert property (is_root && $past(is_root) |-> root_cost == 32'h0)
    else $error("root cost not zero");
  root_port_a: assert property (is_root && $past(is_root) |-> root_port == 16'h0)
    else $error("root port not zero");
  tick_period_a: assert property (tick && seen |-> gap == TICK_CYCLES - 1)
    else $error("tick spacing wrong");
  tx_root_a: assert property (|cfg_tx && $past(is_root) |-> tx_root_id == tx_bridge_id)
    else $error("sent root id not own id");
  hold_gap_a: assert property (cfg_tx[0] && !tick |=> !cfg_tx[0] until tick)
    else $error("second message inside hold");
  tcn_side_a: assert property (tcn_tx |-> !$past(is_root))
    else $error("notice sent by root");
  tca_clear_a: assert property (cfg_tx[1] && !tcn_rx[1] |=> !tx_tca[1])
    else $error("ack flag not cleared");
  learn_order_a: assert property ($rose(port_fwd[0]) |-> $past(port_learn[0]))
    else $error("forwarding without learning");
endmodule
bind stbp_bridge stbp_checker #(.NPORTS(NPORTS), .TICK_CYCLES(TICK_CYCLES)) chk (
  .pclk, .presetn, .tcn_rx, .tick, .cfg_tx, .tcn_tx, .tx_root_id, .tx_bridge_id,
  .tx_tca, .root_port, .root_cost, .is_root, .port_learn, .port_fwd
);

// ==== sim/stbp_peer.sv ====
`timescale 1ns/1ps
// ==========================================
// Neighbour bridge: relays root messages, acks notices late
module stbp_peer (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       tcn_tx,
  input  wire       req,
  input  wire [7:0] age,
  input  wire [7:0] ack_wait,
  output reg        rx_valid,
  output reg        rx_tca,
  output reg  [7:0] rx_msg_age
);
  reg [7:0] wait_cnt;
  // A notice carries nothing, so only its arrival starts the ack countdown
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_cnt   <= 8'h00;
      rx_valid   <= 1'b0;
      rx_tca     <= 1'b0;
      rx_msg_age <= 8'h00;
    end
    else
    begin
      rx_valid   <= req | (wait_cnt == 8'h01);
      rx_tca     <= wait_cnt == 8'h01;
      rx_msg_age <= req ? age : (wait_cnt == 8'h01) ? 8'h01 : ~rx_msg_age;
      wait_cnt   <= (tcn_tx && wait_cnt == 8'h00) ? ack_wait :
                    (wait_cnt != 8'h00) ? wait_cnt - 8'h01 : 8'h00;
    end
  end
endmodule

// ==== sim/stbp_bridge_bench.sv ====
`timescale 1ns/1ps
// ==========================================
// Bench: APB and port stimulus against the bridge block
module stbp_bridge_bench;
  reg          pclk, presetn, psel, penable, pwrite, info_expired, tc_event, rx_tc, req;
  reg  [11:0]  paddr;
  reg  [31:0]  pwdata;
  reg  [32:0]  rv;
  reg  [3:0]   port_en, port_designated, tcn_rx, cfg_due, port_start, rx_port_sel;
  reg  [127:0] port_dcost;
  reg  [255:0] port_dbridge;
  reg  [63:0]  port_dport, rx_root_id;
  reg  [7:0]   rx_max_age, rx_fwd, age;
  wire [7:0]   rx_hello = 8'h03;
  wire [3:0]   port_block = 4'h0;
  wire [31:0]  prdata, root_cost, tx_cost;
  wire [63:0]  tx_root_id, tx_bridge_id;
  wire [15:0]  root_port, ageing_time;
  wire [7:0]   rx_msg_age, tx_max_age, tx_hello, tx_fwd;
  wire [3:0]   cfg_tx, tx_tca, port_learn, port_fwd;
  wire         pready, pslverr, tick, tcn_tx, tx_tc, is_root, rx_valid, rx_tca;
  integer      err_total, checks, tcn_n, tx0_n, a, c;

  stbp_bridge #(.NPORTS(4), .TICK_CYCLES(10)) dut (.*);
  stbp_peer peer (.pclk, .presetn, .tcn_tx, .req, .age, .ack_wait(8'h19), .rx_valid, .rx_tca, .rx_msg_age);

  // Free-running clock
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  // Pulse tallies, so counting needs no sampling races
  always @(posedge pclk)
  begin
    tcn_n <= tcn_n + tcn_tx;
    tx0_n <= tx0_n + cfg_tx[0];
  end
  // ==========================================
  // Tasks
  task chk(input [127:0] g, input [127:0] e);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  end
  endtask
  task to;
  begin
    err_total = err_total + 1;
    $display("MISMATCH %0t wait timed out", $time);
    report_and_stop;
  end
  endtask
  task apb(input w, input [11:0] ad, input [31:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    c = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && c < 50) begin @(posedge pclk); c = c + 1; end
    if (c == 50) to;
    rv = {pslverr, prdata};
    psel <= 1'b0; penable <= 1'b0;
  end
  endtask
  task rd(input [11:0] ad, input [32:0] e);
  begin
    apb(1'b0, ad, 32'h0);
    chk(rv, e);
  end
  endtask
  task settle(input integer n);
  begin
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  end
  endtask
  // Wait for a tick so a hold window cannot expire mid-step
  task sync;
  begin
    c = 0;
    @(negedge pclk);
    while (tick !== 1'b1 && c < 20) begin @(negedge pclk); c = c + 1; end
    if (c == 20) to;
  end
  endtask
  task rx(input [7:0] m);
  begin
    @(posedge pclk); age <= m; req <= 1'b1;
    @(posedge pclk); req <= 1'b0;
    settle(3);
  end
  endtask
  task send(input [3:0] m, input [3:0] e);
  begin
    @(posedge pclk); cfg_due <= m;
    @(posedge pclk); cfg_due <= 4'h0;
    @(negedge pclk);
    chk(cfg_tx, e);
  end
  endtask
  task roots(input [63:0] b1, input [63:0] b2, input [15:0] d1, input [15:0] d2, input [15:0] e);
  begin
    @(posedge pclk);
    port_dbridge[127:64] <= b1; port_dbridge[191:128] <= b2;
    port_dport[31:16] <= d1; port_dport[47:32] <= d2;
    settle(2);
    chk(root_port, e);
    chk(root_cost, 32'h18);
  end
  endtask
  task waitp(input s);
  begin
    c = 0;
    @(negedge pclk);
    while ((s ? port_fwd[0] : port_learn[0]) !== 1'b1 && c < 200) begin @(negedge pclk); c = c + 1; end
    if (c == 200) to;
    chk(c > 134 && c < 161, 1);
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, info_expired, tc_event, rx_tc, req} = 7'h00;
    paddr = 12'h000; pwdata = 32'h0; age = 8'h00;
    port_en = 4'hF; port_designated = 4'h0; tcn_rx = 4'h0; cfg_due = 4'h0; port_start = 4'h0;
    rx_port_sel = 4'h4; rx_root_id = 64'h7FFF_FFFF_FFFF_FFFF; rx_max_age = 8'h1E; rx_fwd = 8'h09;
    port_dcost = {32'h14, 32'h5, 32'h5, 32'hA};
    port_dbridge = {64'h9, 64'h1, 64'h2, 64'h9};
    port_dport = {16'h1, 16'h1, 16'h1, 16'h1};
    err_total = 0; checks = 0; tcn_n = 0; tx0_n = 0; presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h004, 33'h080000000);
    rd(12'h00C, 33'h0000F0214);
    rd(12'h010, 33'h00000012C);
    rd(12'h0FC, 33'h100000000);
    for (a = 0; a < 4; a = a + 1) apb(1'b1, 12'(12'h044 + 8 * a), 32'h8004 - a);
    $display("registers done");
    rx(8'h15);
    chk(is_root, 1);
    @(posedge pclk); rx_tc <= 1'b1;
    rx(8'h14);
    chk(is_root, 0);
    chk(root_port, 16'h8002);
    chk(root_cost, 32'h18);
    rd(12'h024, 33'h00909031E);
    sync;
    send(4'h1, 4'h1);
    chk({tx_root_id, tx_cost}, {64'h7FFF_FFFF_FFFF_FFFF, 32'h18});
    chk({tx_bridge_id, tx_tc}, {64'h8000_0000_0000_0001, 1'b1});
    chk({tx_max_age, tx_hello, tx_fwd}, 24'h1E0309);
    @(posedge pclk); rx_tc <= 1'b0;
    rx(8'h01);
    chk(ageing_time, 16'h012C);
    $display("receive done");
    @(posedge pclk); port_en[3] <= 1'b0;
    sync;
    // One immediate send plus one deferred; the due on disabled port 3 sends nothing
    a = tx0_n;
    send(4'h1, 4'h1);
    send(4'h9, 4'h0);
    settle(25);
    chk(tx0_n - a, 2);
    @(posedge pclk); port_en[3] <= 1'b1;
    $display("hold done");
    sync;
    a = tcn_n;
    @(posedge pclk); tc_event <= 1'b1;
    @(posedge pclk); tc_event <= 1'b0;
    settle(100);
    chk(tcn_n - a, 2);
    @(posedge pclk); port_designated <= 4'h2;
    tcn_rx <= 4'h2;
    @(posedge pclk); tcn_rx <= 4'h0;
    @(negedge pclk);
    chk(tx_tca[1], 1);
    send(4'h2, 4'h2);
    settle(1);
    chk(tx_tca[1], 0);
    @(posedge pclk); port_designated <= 4'h0;
    $display("notice done");
    roots(64'h1, 64'h1, 16'h1, 16'h2, 16'h8003);
    roots(64'h1, 64'h1, 16'h1, 16'h1, 16'h8002);
    $display("ties done");
    @(posedge pclk); info_expired <= 1'b1;
    @(posedge pclk); info_expired <= 1'b0;
    settle(2);
    chk({is_root, root_port, root_cost}, 49'h1_0000_0000_0000);
    apb(1'b1, 12'h000, 32'h2);
    settle(2);
    chk(ageing_time, 16'h000F);
    sync;
    send(4'h1, 4'h1);
    chk({tx_tc, tx_max_age, tx_hello, tx_fwd}, 25'h114020F);
    chk(tx_root_id, 64'h8000_0000_0000_0001);
    settle(300);
    chk(ageing_time, 16'h000F);
    settle(50);
    chk(ageing_time, 16'h012C);
    $display("root done");
    @(posedge pclk); port_start <= 4'h1;
    @(posedge pclk); port_start <= 4'h0;
    waitp(1'b0);
    waitp(1'b1);
    $display("port states done");
    report_and_stop;
  end
endmodule
